// >>> pkg/pdm_pkg.sv
// package for the piezo driver mode sequencer
// assumes a single 200 MHz clock and nothing else outside this block
package pdm_pkg;
  // -------------------------------------------------------------------------
  // timing
  // -------------------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 5000; // 200 MHz
  localparam int T_OCP_DEG_PS = 600000; // overcurrent deglitch, 0.6 us
  // least time, so round up to whole cycles
  localparam int OCP_DEG_CYC = (T_OCP_DEG_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int T_SLEEP_CYC_DEF = 4000; // sleep-entry interval, plain default
  localparam int T_WAKE_CYC_DEF = 4000; // wake interval, plain default
  localparam int T_RST_CYC_DEF = 2000; // fault-reset window, plain default
  localparam int T_REG_CYC_DEF = 1000; // regulator settling, below both intervals
  localparam int DGL_CYC = 4; // input deglitch length
  localparam int CNT_W = 16;
  localparam int DGL_W = 3;
  localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;

  // -------------------------------------------------------------------------
  // types
  // -------------------------------------------------------------------------
  typedef enum logic [2:0] {
    PDM_SLEEP, PDM_WAKE, PDM_OPER, PDM_RSTLOW, PDM_SLEEPING
  } pdm_state_t;

  // enables toward the analog blocks
  typedef struct packed {
    logic out_stage_en;
    logic predrv_en;
    logic charge_pump_en;
    logic analog_reg_en;
  } pdm_power_t;
  localparam pdm_power_t PWR_RESET = 4'h0;
endpackage : pdm_pkg

// >>> design/pdm_deglitch.sv
// two-flop synchroniser plus a stable-count deglitch filter
// assumes async input; output moves only after DGL_CYC equal samples
`timescale 1ns/10ps
module pdm_deglitch
  import pdm_pkg::*;
#(
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic mclk, // clock
  input wire logic rst_n, // async reset, active low
  input wire logic din, // raw pin level
  output logic dout // filtered level
);
  logic s1_reg;
  logic s2_reg;
  logic [DGL_W-1:0] cnt_reg;

  // synchroniser, first flop read only by the second
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg <= RESET_VAL;
      s2_reg <= RESET_VAL;
    end else begin
      s1_reg <= din;
      s2_reg <= s1_reg;
    end
  end

  // filter: short glitches never reach the state machine
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= '0;
      dout <= RESET_VAL;
    end else if (s2_reg == dout) begin
      cnt_reg <= '0;
    end else if (cnt_reg == DGL_W'(DGL_CYC - 1)) begin
      cnt_reg <= '0;
      dout <= s2_reg;
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end
endmodule : pdm_deglitch

// >>> design/pdm_mode_ctrl.sv
// mode and reset sequencer of a dual half-bridge piezo driver
// assumes mclk is the internal 200 MHz clock; pins and analog flags are async
`timescale 1ns/10ps
module pdm_mode_ctrl
  import pdm_pkg::*;
#(
  parameter int T_SLEEP_CYC = T_SLEEP_CYC_DEF, // sleep-entry interval in cycles
  parameter int T_WAKE_CYC = T_WAKE_CYC_DEF, // wake interval in cycles
  parameter int T_RST_CYC = T_RST_CYC_DEF, // fault-reset window in cycles
  parameter int T_REG_CYC = T_REG_CYC_DEF // regulator switching time in cycles
) (
  input wire logic mclk, // 200 MHz internal clock
  input wire logic rst_n, // async power-on reset, active low
  input wire logic sleep_reset_n, // reset/sleep pin, active low
  input wire logic output_kill, // output-kill pin, active high
  input wire logic [1:0] half_bridge_inputs, // pwm inputs per half bridge
  input wire logic supply_lockout, // supply below supply_lockout_level
  input wire logic overcurrent_trip, // raw overcurrent comparator
  input wire logic cp_undervolt, // charge pump undervoltage, self-clearing
  output logic fault_out_n, // open-drain fault, low active
  output logic fault_out_oe, // drive enable for fault_out_n, high drives low
  output pdm_power_t power_en, // enables toward analog blocks
  output logic [1:0] hb_drive, // gated half-bridge commands
  output logic ready // device accepts inputs
);
  // -------------------------------------------------------------------------
  // input conditioning
  // -------------------------------------------------------------------------
  logic rstz_f;
  logic kill_f;
  logic lock_s1_reg;
  logic lock_s2_reg;
  logic ocp_s1_reg;
  logic ocp_s2_reg;
  logic cpuv_s1_reg;
  logic cpuv_s2_reg;
  logic [1:0] hb_s1_reg;
  logic [1:0] hb_s2_reg;

  // pin filters: reset idles low so the device starts asleep
  pdm_deglitch #(.RESET_VAL(1'b0)) u_rstz_dgl (
    .mclk(mclk),
    .rst_n(rst_n),
    .din(sleep_reset_n),
    .dout(rstz_f)
  );
  pdm_deglitch #(.RESET_VAL(1'b1)) u_kill_dgl (
    .mclk(mclk),
    .rst_n(rst_n),
    .din(output_kill),
    .dout(kill_f)
  );

  // plain two-flop synchronisers, one process per concern; the first flop
  // of each pair is read only by its second flop
  // supply lockout resets high, so the FETs stay off until the flag is seen
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lock_s1_reg <= 1'b1;
      lock_s2_reg <= 1'b1;
    end else begin
      lock_s1_reg <= supply_lockout;
      lock_s2_reg <= lock_s1_reg;
    end
  end

  // overcurrent comparator; its deglitch is the counter further down
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ocp_s1_reg <= 1'b0;
      ocp_s2_reg <= 1'b0;
    end else begin
      ocp_s1_reg <= overcurrent_trip;
      ocp_s2_reg <= ocp_s1_reg;
    end
  end

  // charge pump undervoltage, self-clearing in the analog block
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cpuv_s1_reg <= 1'b0;
      cpuv_s2_reg <= 1'b0;
    end else begin
      cpuv_s1_reg <= cp_undervolt;
      cpuv_s2_reg <= cpuv_s1_reg;
    end
  end

  // pwm inputs: each bit is a plain level, so a one-cycle skew between the
  // two bits only delays one edge, it never makes a glitch
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      hb_s1_reg <= 2'h0;
      hb_s2_reg <= 2'h0;
    end else begin
      hb_s1_reg <= half_bridge_inputs;
      hb_s2_reg <= hb_s1_reg;
    end
  end

  // -------------------------------------------------------------------------
  // state machine
  // -------------------------------------------------------------------------
  pdm_state_t state_reg;
  pdm_state_t state_next;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] ocp_cnt_reg;
  logic latch_reg;
  logic latch_set;
  logic pulse_done;
  logic cnt_clr;

  // counter limits at the counter's width
  localparam logic [CNT_W-1:0] LIM_SLEEP = CNT_W'(T_SLEEP_CYC);
  localparam logic [CNT_W-1:0] LIM_WAKE = CNT_W'(T_WAKE_CYC);
  localparam logic [CNT_W-1:0] LIM_RST = CNT_W'(T_RST_CYC);
  localparam logic [CNT_W-1:0] LIM_REG = CNT_W'(T_REG_CYC);
  localparam logic [CNT_W-1:0] LIM_OCP = CNT_W'(OCP_DEG_CYC);

  // -------------------------------------------------------------------------
  // state decoding shared by the counter, the latch and the outputs
  // -------------------------------------------------------------------------
  // the one state in which half-bridge commands may pass
  function automatic logic is_oper(input pdm_state_t st);
    return (st == PDM_OPER);
  endfunction : is_oper

  // states that keep the charge pump and analog regulator up throughout
  function automatic logic regs_state(input pdm_state_t st);
    return (st == PDM_WAKE) || (st == PDM_OPER) || (st == PDM_RSTLOW);
  endfunction : regs_state

  // last T_REG_CYC cycles of the sleep entry, while the regulators go down;
  // both the regulator enables and the fault pin follow this one window
  function automatic logic sleep_tail(input pdm_state_t st, input logic [CNT_W-1:0] cnt);
    return (st == PDM_SLEEPING) && (cnt >= LIM_SLEEP - LIM_REG);
  endfunction : sleep_tail

  // first T_REG_CYC cycles of wake, while the regulators ramp up
  function automatic logic wake_head(input pdm_state_t st, input logic [CNT_W-1:0] cnt);
    return (st == PDM_WAKE) && (cnt < LIM_REG);
  endfunction : wake_head

  // the sequence as the pin sees it:
  //   SLEEP     everything off, waiting for the filtered pin to go high
  //   WAKE      regulators ramp; fault held low for the first T_REG_CYC
  //             cycles, commands refused until T_WAKE_CYC has run
  //   OPER      regulators up; FETs follow the synchronised pwm inputs
  //   RSTLOW    pin low in operation; a return before T_RST_CYC is only a
  //             fault reset, reaching it commits to sleep
  //   SLEEPING  committed sleep entry of T_SLEEP_CYC cycles; regulators drop
  //             and fault is held low in the last T_REG_CYC of them
  // the pin filter adds about six cycles to every edge, so each window seen
  // at the pin is that much longer than its count here

  // next state; counter restarts on every state change
  always_comb begin
    state_next = state_reg;
    pulse_done = 1'b0;
    unique case (state_reg)
      PDM_SLEEP: begin
        if (rstz_f) begin
          state_next = PDM_WAKE;
        end
      end
      PDM_WAKE: begin
        if (!rstz_f) begin
          state_next = PDM_SLEEPING;
        end else if (cnt_reg >= LIM_WAKE - 1'b1 && !lock_s2_reg) begin
          state_next = PDM_OPER;
        end
      end
      PDM_OPER: begin
        if (!rstz_f) begin
          state_next = PDM_RSTLOW;
        end
      end
      PDM_RSTLOW: begin
        if (rstz_f) begin
          state_next = PDM_OPER;
          pulse_done = 1'b1;
        end else if (cnt_reg >= LIM_RST - 1'b1) begin
          state_next = PDM_SLEEPING;
        end
      end
      PDM_SLEEPING: begin
        // once committed, the sleep entry runs to its end
        if (cnt_reg >= LIM_SLEEP - 1'b1) begin
          state_next = PDM_SLEEP;
        end
      end
      default: begin
        // three codes of the state register are unused; fall back to sleep
        state_next = PDM_SLEEP;
      end
    endcase
  end

  assign cnt_clr = (state_next != state_reg);

  // state register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= PDM_SLEEP;
    end else begin
      state_reg <= state_next;
    end
  end

  // interval counter, saturating
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= CNT_RESET;
    end else if (cnt_clr) begin
      cnt_reg <= CNT_RESET;
    end else if (cnt_reg != {CNT_W{1'b1}}) begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

  // -------------------------------------------------------------------------
  // overcurrent deglitch and fault latch
  // -------------------------------------------------------------------------
  // masked while killed, because the drivers are off by design then
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ocp_cnt_reg <= CNT_RESET;
    end else if (!ocp_s2_reg || kill_f || !is_oper(state_reg)) begin
      ocp_cnt_reg <= CNT_RESET;
    end else if (ocp_cnt_reg != LIM_OCP) begin
      ocp_cnt_reg <= ocp_cnt_reg + 1'b1;
    end
  end

  assign latch_set = (ocp_cnt_reg == LIM_OCP);

  // a set in the same cycle as the clearing pulse wins; a clear only takes
  // effect once the comparator has dropped, except the clear on reaching full sleep
  // limitation: a comparator still high at the end of the pulse leaves the
  // latch set, and the host must send another pulse after the trip is gone
  // reaching full sleep also clears it, since the output stage restarts cold
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      latch_reg <= 1'b0;
    end else if (latch_set) begin
      latch_reg <= 1'b1;
    end else if (state_reg == PDM_SLEEP) begin
      latch_reg <= 1'b0;
    end else if (pulse_done && !ocp_s2_reg) begin
      latch_reg <= 1'b0;
    end
  end

  // -------------------------------------------------------------------------
  // outputs
  // -------------------------------------------------------------------------
  logic regs_on;
  logic fets_ok;
  logic reg_trans;
  logic fault_now;

  // regulators stay on through a fault-reset pulse and the kill input
  assign regs_on = regs_state(state_reg) ||
                   ((state_reg == PDM_SLEEPING) && !sleep_tail(state_reg, cnt_reg));
  assign fets_ok = is_oper(state_reg) && !lock_s2_reg && !latch_reg &&
                   !kill_f && !cpuv_s2_reg;
  // regulator switching window: start of wake and end of sleep entry
  assign reg_trans = wake_head(state_reg, cnt_reg) || sleep_tail(state_reg, cnt_reg);
  // kill can starve the charge pump, which then shows here as a fault
  assign fault_now = reg_trans || latch_reg || latch_set || cpuv_s2_reg;

  // power enables, registered
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      power_en <= PWR_RESET;
    end else begin
      power_en.charge_pump_en <= regs_on;
      power_en.analog_reg_en <= regs_on;
      power_en.out_stage_en <= fets_ok;
      power_en.predrv_en <= fets_ok;
    end
  end

  // gated half-bridge commands; registered in the same cycle as the enables,
  // so no command ever reaches a stage that is being switched off
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      hb_drive <= 2'h0;
    end else begin
      hb_drive <= fets_ok ? hb_s2_reg : 2'h0;
    end
  end

  // ready flag: high only once the wake interval has run out
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ready <= 1'b0;
    end else begin
      ready <= is_oper(state_reg);
    end
  end

  // open-drain fault pin: level is always low, enable does the work
  // the pin never drives high, so a board pull-up is what shows no fault;
  // a shared fault line may be pulled low by other parts at the same time
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      fault_out_n <= 1'b0;
      fault_out_oe <= 1'b0;
    end else begin
      fault_out_n <= 1'b0;
      fault_out_oe <= fault_now;
    end
  end
endmodule : pdm_mode_ctrl

// >>> sim/pdm_mode_ctrl_asserts.sv
// concurrent checks on the mode sequencer ports
// assumes the single mclk domain and rst_n as the only reset
`timescale 1ns/10ps
module pdm_mode_ctrl_asserts
  import pdm_pkg::*;
#(
  parameter int T_SLEEP_CYC = 40,
  parameter int T_WAKE_CYC = 40,
  parameter int T_RST_CYC = 20,
  parameter int T_REG_CYC = 10
) (
  input wire logic mclk, // clock
  input wire logic rst_n, // reset
  input wire logic sleep_reset_n, // sleep pin
  input wire logic output_kill, // kill pin
  input wire logic [1:0] half_bridge_inputs, // pwm pins
  input wire logic supply_lockout, // lockout flag
  input wire logic overcurrent_trip, // overcurrent flag
  input wire logic cp_undervolt, // pump flag
  input wire logic fault_out_n, // fault data
  input wire logic fault_out_oe, // fault drive
  input wire pdm_power_t power_en, // analog enables
  input wire logic [1:0] hb_drive, // gated pwm
  input wire logic ready // accepts inputs
);
  // -------------------------------------------------------------------------
  // helper counters and properties
  // -------------------------------------------------------------------------
  logic [CNT_W-1:0] low_cnt_reg;
  logic [CNT_W-1:0] oc_cnt_reg;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // saturating count of pin low cycles, so a long sleep never wraps
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) low_cnt_reg <= CNT_RESET;
    else if (sleep_reset_n) low_cnt_reg <= CNT_RESET;
    else if (low_cnt_reg != 16'hffff) low_cnt_reg <= low_cnt_reg + 16'h0001;
  end
  // count of unmasked overcurrent cycles
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) oc_cnt_reg <= CNT_RESET;
    else if (!overcurrent_trip || output_kill) oc_cnt_reg <= CNT_RESET;
    else if (oc_cnt_reg != 16'hffff) oc_cnt_reg <= oc_cnt_reg + 16'h0001;
  end
  sequence reg_settle;
    fault_out_oe ##[1:T_WAKE_CYC] !fault_out_oe;
  endsequence
  sequence kill_held;
    output_kill [*8] ##1 output_kill [*4];
  endsequence
  chk_reset_all_off: assert property ($rose(rst_n) |-> power_en == 4'h0 && !ready)
    else $error("outputs not off after reset");
  chk_pwm_needs_ready: assert property (hb_drive != 2'h0 |-> ready)
    else $error("pwm passed while not ready");
  chk_oper_regs_on: assert property (ready |-> power_en.charge_pump_en && power_en.analog_reg_en)
    else $error("regulators off while operating");
  chk_sleep_all_off: assert property (low_cnt_reg >= CNT_W'(T_RST_CYC + T_SLEEP_CYC + 16) |->
    power_en == 4'h0 && !ready && !fault_out_oe) else $error("not asleep after long low");
  chk_kill_fets_off: assert property (kill_held |-> hb_drive == 2'h0 &&
    !power_en.predrv_en && !power_en.out_stage_en) else $error("fets on under kill");
  chk_lockout_fets: assert property (supply_lockout [*4] |-> hb_drive == 2'h0)
    else $error("fets on under lockout");
  chk_wake_fault_pulse: assert property ($rose(power_en.analog_reg_en) |-> reg_settle)
    else $error("fault not held then released on wake");
  chk_ocp_latch_trip: assert property (oc_cnt_reg == CNT_W'(OCP_DEG_CYC + 6) |->
    fault_out_oe && hb_drive == 2'h0 && !power_en.out_stage_en) else $error("overcurrent not latched");
endmodule : pdm_mode_ctrl_asserts

bind pdm_mode_ctrl pdm_mode_ctrl_asserts #(.T_SLEEP_CYC(T_SLEEP_CYC), .T_WAKE_CYC(T_WAKE_CYC),
  .T_RST_CYC(T_RST_CYC), .T_REG_CYC(T_REG_CYC)) u_chk (.mclk(mclk), .rst_n(rst_n),
  .sleep_reset_n(sleep_reset_n), .output_kill(output_kill), .half_bridge_inputs(half_bridge_inputs),
  .supply_lockout(supply_lockout), .overcurrent_trip(overcurrent_trip), .cp_undervolt(cp_undervolt),
  .fault_out_n(fault_out_n), .fault_out_oe(fault_out_oe), .power_en(power_en),
  .hb_drive(hb_drive), .ready(ready));

// >>> sim/pdm_host_model.sv
// host processor model driving the sleep pin and the pwm pins
// assumes the bench calls its tasks on the falling edge of mclk
`timescale 1ns/10ps
module pdm_host_model
  import pdm_pkg::*;
(
  input wire logic mclk, // device clock
  input wire logic ready, // device accepts inputs
  input wire logic [1:0] pwm_req, // wanted pwm levels
  output logic sleep_reset_n, // sleep pin
  output logic [1:0] half_bridge_inputs // pwm pins
);
  // -------------------------------------------------------------------------
  // pin drivers
  // -------------------------------------------------------------------------
  // the host, not a regulator-powered controller, owns the sleep pin
  initial sleep_reset_n = 1'b0;
  initial half_bridge_inputs = 2'h0;
  // pwm held off until the device reports it accepts inputs
  always @(negedge mclk) half_bridge_inputs <= ready ? pwm_req : 2'h0;
  task drive(input logic lvl);
    @(negedge mclk);
    sleep_reset_n = lvl;
  endtask : drive
  // high-low-high pulse; len picks fault reset or full shutdown
  task pulse(input int len);
    @(negedge mclk);
    sleep_reset_n = 1'b0;
    repeat (len) @(negedge mclk);
    sleep_reset_n = 1'b1;
  endtask : pulse
endmodule : pdm_host_model

// >>> sim/test_piezo_driver_mode_control.sv
// self-checking bench for the mode sequencer with a host model
// assumes shortened intervals; outputs sampled on the falling edge
`timescale 1ns/10ps
module test_piezo_driver_mode_control
  import pdm_pkg::*;
;
  // -------------------------------------------------------------------------
  // bench
  // -------------------------------------------------------------------------
  localparam int TS = 40;
  localparam int TW = 40;
  localparam int TR = 20;
  localparam int TG = 10;
  typedef struct packed {logic rdy; logic pin; logic [1:0] hb; pdm_power_t pwr;} pdm_note_t;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic output_kill = 1'b0;
  logic supply_lockout = 1'b0;
  logic overcurrent_trip = 1'b0;
  logic cp_undervolt = 1'b0;
  logic [1:0] pwm_req = 2'h0;
  logic [7:0] seed = 8'h0d;
  logic sleep_reset_n, fault_out_n, fault_out_oe, ready;
  logic [1:0] half_bridge_inputs, hb_drive;
  pdm_power_t power_en;
  wire logic fault_pin;
  int fails = 0;
  int samples_checked = 0;
  int i;
  pdm_note_t notes[$];
  event note_ev;
  // open-drain pin with its pull-up
  assign fault_pin = fault_out_oe ? fault_out_n : 1'b1;
  always #2.5 mclk = ~mclk;
  pdm_host_model host (.mclk(mclk), .ready(ready), .pwm_req(pwm_req),
    .sleep_reset_n(sleep_reset_n), .half_bridge_inputs(half_bridge_inputs));
  pdm_mode_ctrl #(.T_SLEEP_CYC(TS), .T_WAKE_CYC(TW), .T_RST_CYC(TR), .T_REG_CYC(TG)) dut (
    .mclk(mclk), .rst_n(rst_n), .sleep_reset_n(sleep_reset_n), .output_kill(output_kill),
    .half_bridge_inputs(half_bridge_inputs), .supply_lockout(supply_lockout),
    .overcurrent_trip(overcurrent_trip), .cp_undervolt(cp_undervolt), .fault_out_n(fault_out_n),
    .fault_out_oe(fault_out_oe), .power_en(power_en), .hb_drive(hb_drive), .ready(ready));
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  task stop_test();
    if (fails == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : stop_test
  task cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask : cyc
  task note(input pdm_note_t e);
    notes.push_back(e);
    -> note_ev;
  endtask : note
  task cmp_note(input pdm_note_t e, input pdm_note_t g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("BAD %0t outputs %h want %h", $time, g, e);
    end
  endtask : cmp_note
  task chk(input logic ok);
    samples_checked++;
    if (ok !== 1'b1) begin
      fails++;
      $display("BAD %0t level or timing wrong", $time);
    end
  endtask : chk
  // bounded wait, the count is the wake time seen
  task wait_rdy(output int n);
    for (n = 0; n < 300 && ready !== 1'b1; n++) cyc(1);
  endtask : wait_rdy
  // monitor pairs each note with the outputs present when it is posted
  always @(note_ev) cmp_note(notes.pop_front(), {ready, fault_pin, hb_drive, power_en});
  initial begin
    cyc(6);
    rst_n = 1'b1;
    cyc(2);
    note('{1'b0, 1'b1, 2'h0, 4'h0});
    host.drive(1'b1);
    for (i = 0; i < 100 && power_en.analog_reg_en !== 1'b1; i++) cyc(1);
    cyc(1);
    chk(fault_pin === 1'b0 && ready === 1'b0);
    wait_rdy(i);
    chk(i >= TW - 2);
    repeat (4) begin
      seed = lfsr(seed);
      pwm_req = seed[1:0];
      cyc(6);
      note('{1'b1, 1'b1, seed[1:0], 4'hf});
    end
    cp_undervolt = 1'b1;
    cyc(4);
    note('{1'b1, 1'b0, 2'h0, 4'h3});
    cp_undervolt = 1'b0;
    cyc(4);
    pwm_req = 2'h3;
    output_kill = 1'b1;
    overcurrent_trip = 1'b1;
    cyc(200);
    note('{1'b1, 1'b1, 2'h0, 4'h3});
    overcurrent_trip = 1'b0;
    cyc(2);
    output_kill = 1'b0;
    supply_lockout = 1'b1;
    cyc(6);
    supply_lockout = 1'b0;
    wait_rdy(i);
    cyc(10);
    overcurrent_trip = 1'b1;
    cyc(OCP_DEG_CYC - 10);
    chk(fault_pin === 1'b1);
    cyc(20);
    note('{1'b1, 1'b0, 2'h0, 4'h3});
    overcurrent_trip = 1'b0;
    cyc(10);
    chk(fault_pin === 1'b0);
    host.pulse(TR / 2);
    cyc(20);
    note('{1'b1, 1'b1, 2'h3, 4'hf});
    host.drive(1'b0);
    cyc(TR + 10);
    chk(power_en.analog_reg_en === 1'b1);
    cyc(TS + 20);
    note('{1'b0, 1'b1, 2'h0, 4'h0});
    host.drive(1'b1);
    wait_rdy(i);
    chk(ready === 1'b1);
    stop_test();
  end
  // about 620 cycles are expected; nearly ten times that means a hang
  initial begin
    #30us;
    fails++;
    stop_test();
  end
endmodule : test_piezo_driver_mode_control
